//--- src/drive_terminal_command_decoder.sv
// Functional notes
// - mode 0 fwd/rev inputs, 1 run plus direction, 2 three-wire.
// - in mode 0, forward and reverse together mean stop; in mode 1 they run reverse.
// - three-wire mode takes terminals one to three, ignoring their codes.
// - reverse inhibit rejects every reverse command.
// - terminal run source keeps keypad stop as emergency stop.
// - each terminal takes one of 23 function codes 0 to 22.
// - codes 0/1 run forward/reverse while held; defaults terminal one/two.
// - codes 2..5 form a 1/2/4/8 preset index, zero is base.
// - frequency priority jog, then preset, then normal source.
// - codes 6/7 jog forward/reverse with jog ramp times.
// - jog frequency limited to 1.00..25.00 Hz.
// - jog ramp times limited to 0.1..25.5 s.
// - code 8 selects ramp pair two; jog overrides both.
// - code 9 stops on decel two, flashes indicator, ignores stop method.
// - emergency stop completes; run must drop and return, or keypad run be pressed, to restart.
// - fault on emergency stop only with output mode 9.
// - code 10 cuts output to coast and flashes indicator.
// - code 11 requests speed search at start.
// - code 12 requests gradual energy-saving voltage reduction.
// - code 13 picks alternate run source when held.
// - code 14 freezes ramping while held.
// - inputs sampled each 2 ms, accepted after 1..200 equal scans.
// - up and down together are ignored.
`timescale 1ns/1ps
`include "term_cmd_defines.svh"
module drive_terminal_command_decoder (
  input wire logic mclk_i,                        // 40 MHz clock
  input wire logic rst_b_i,                       // async reset, low
  input wire logic ce_i,                          // clock enable
  input wire logic [5:0] term_pin_i,              // raw terminal pins
  input wire term_cmd_pkg::func_code_t func_i [6], // function per terminal
  input wire term_cmd_pkg::run_mode_t run_mode_i, // terminal run mode
  input wire term_cmd_pkg::run_src_t main_src_i,  // main run source
  input wire term_cmd_pkg::run_src_t alt_src_i,   // alternate run source
  input wire logic rev_inhibit_i,                 // 1 blocks reverse
  input wire logic [7:0] scan_count_i,            // equal scans needed
  input wire term_cmd_pkg::fault_mode_t fault_mode_i, // fault output mode
  input wire logic [15:0] jog_freq_i,             // jog freq, 0.01 Hz
  input wire logic [7:0] jog_acc_i,               // jog accel, 0.1 s
  input wire logic [7:0] jog_dec_i,               // jog decel, 0.1 s
  input wire logic key_stop_i,                    // keypad stop, sync
  input wire logic key_run_i,                     // keypad run, sync
  input wire logic motor_stopped_i,               // ramp reached zero
  output logic run_o,                             // run command
  output logic rev_o,                             // 1 = reverse
  output logic jog_o,                             // jog active
  output term_cmd_pkg::freq_sel_t freq_sel_o,     // frequency source
  output logic [3:0] preset_idx_o,                // preset index
  output term_cmd_pkg::ramp_sel_t ramp_sel_o,     // ramp time set
  output logic [15:0] jog_freq_o,                 // clamped jog freq
  output logic [7:0] jog_acc_o,                   // clamped jog accel
  output logic [7:0] jog_dec_o,                   // clamped jog decel
  output logic estop_o,                           // decel-2 stop active
  output logic estop_flash_o,                     // emergency indicator
  output logic coast_o,                           // output cut
  output logic coast_flash_o,                     // coast indicator
  output logic fault_o,                           // fault output
  output logic speed_search_o,                    // speed search request
  output logic energy_save_o,                     // energy saving request
  output logic alt_src_o,                         // alternate source used
  output logic ramp_hold_o,                       // ramp frozen
  output logic up_o,                              // up step request
  output logic down_o                             // down step request
);
  import term_cmd_pkg::*;

  // ----------------------------------------
  // scan filter and three-wire latch
  // ----------------------------------------
  term_bus_if tb ();
  logic tw_run;
  logic tw_rev;
  logic three_wire;

  assign three_wire = (run_mode_i == `RUN_MODE_THREE_WIRE);

  term_scan_filter u_filter (
    .mclk_i (mclk_i),
    .rst_b_i (rst_b_i),
    .ce_i (ce_i),
    .pin_i (term_pin_i),
    .scans_i (scan_count_i),
    .bus (tb.src)
  );

  three_wire_latch u_three (
    .mclk_i (mclk_i),
    .rst_b_i (rst_b_i),
    .ce_i (ce_i),
    .enable_i (three_wire),
    .bus (tb.dst),
    .run_o (tw_run),
    .rev_o (tw_rev)
  );

  // ----------------------------------------
  // function decode
  // ----------------------------------------
  // any terminal with the code asserted, except terminals one to three when skip3 is set
  function automatic logic fn_on(input func_code_t code,
                                 input logic [5:0] lvl,
                                 input func_code_t tab [6],
                                 input logic skip3);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 6; i++) begin
      if (lvl[i] && tab[i] == code && tab[i] <= `FN_LAST &&
          !(skip3 && i < 3)) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : fn_on

  function automatic logic [15:0] clamp16(input logic [15:0] v,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
    return (v < lo) ? lo : (v > hi) ? hi : v;
  endfunction : clamp16

  logic [5:0] lvl;
  logic f_fwd, f_rev, f_jf, f_jr, f_acc2, f_estop, f_bb;
  logic f_ss, f_es, f_src, f_hold, f_up, f_down;
  logic [3:0] pidx;

  assign lvl = tb.level;
  always_comb begin
    f_fwd = fn_on(`FN_FWD, lvl, func_i, three_wire);
    f_rev = fn_on(`FN_REV, lvl, func_i, three_wire);
    f_jf = fn_on(`FN_JOG_FWD, lvl, func_i, three_wire);
    f_jr = fn_on(`FN_JOG_REV, lvl, func_i, three_wire);
    f_acc2 = fn_on(`FN_ACC2, lvl, func_i, three_wire);
    f_estop = fn_on(`FN_ESTOP, lvl, func_i, three_wire);
    f_bb = fn_on(`FN_BASE_BLOCK, lvl, func_i, three_wire);
    f_ss = fn_on(`FN_SPEED_SEARCH, lvl, func_i, three_wire);
    f_es = fn_on(`FN_ENERGY_SAVE, lvl, func_i, three_wire);
    f_src = fn_on(`FN_SRC_SELECT, lvl, func_i, three_wire);
    f_hold = fn_on(`FN_RAMP_HOLD, lvl, func_i, three_wire);
    f_up = fn_on(`FN_UP, lvl, func_i, three_wire);
    f_down = fn_on(`FN_DOWN, lvl, func_i, three_wire);
    pidx = {fn_on(`FN_PRESET3, lvl, func_i, three_wire),
            fn_on(`FN_PRESET2, lvl, func_i, three_wire),
            fn_on(`FN_PRESET1, lvl, func_i, three_wire),
            fn_on(`FN_PRESET0, lvl, func_i, three_wire)};
  end

  // ----------------------------------------
  // run command
  // ----------------------------------------
  run_src_t src;
  logic term_src;
  logic t_run, t_rev, want_run, want_rev, jog_req;

  // code 13 chooses the alternate source
  assign src = f_src ? alt_src_i : main_src_i;
  assign term_src = (src == `SRC_TERMINAL);

  always_comb begin
    t_run = 1'b0;
    t_rev = 1'b0;
    unique case (run_mode_i)
      `RUN_MODE_FWD_REV: begin
        t_run = f_fwd ^ f_rev;
        t_rev = f_rev & ~f_fwd;
      end
      `RUN_MODE_RUN_DIR: begin
        t_run = f_fwd;
        t_rev = f_rev;
      end
      `RUN_MODE_THREE_WIRE: begin
        t_run = tw_run;
        t_rev = tw_rev;
      end
      default: begin
        t_run = 1'b0;
        t_rev = 1'b0;
      end
    endcase
    jog_req = f_jf ^ f_jr;
    want_run = term_src & (t_run | jog_req);
    want_rev = jog_req ? f_jr : t_rev;
  end

  // ----------------------------------------
  // emergency stop and restart lockout
  // ----------------------------------------
  logic estop_r;
  logic relock_r;
  logic flash_r;
  logic [22:0] flash_cnt_r;

  // keypad stop acts as emergency stop when the terminal run source is selected
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      estop_r <= 1'b0;
      relock_r <= 1'b0;
    end else if (ce_i) begin
      if (f_estop || (term_src && key_stop_i)) begin
        estop_r <= 1'b1;
        relock_r <= 1'b1;
      end else if (estop_r && motor_stopped_i) begin
        estop_r <= 1'b0;
      end else if (!estop_r && relock_r &&
                   (!(t_run | jog_req) || key_run_i)) begin
        // run dropped or keypad run re-arms
        relock_r <= 1'b0;
      end
    end
  end

  // slow blink shared by both indicators, about 2.4 Hz, starts lit
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flash_cnt_r <= 23'h000000;
      flash_r <= 1'b0;
    end else if (ce_i) begin
      flash_cnt_r <= flash_cnt_r + 23'h000001;
      if (flash_cnt_r == 23'h000000) flash_r <= ~flash_r;
    end
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      run_o <= 1'b0;
      rev_o <= 1'b0;
      jog_o <= 1'b0;
      alt_src_o <= 1'b0;
    end else if (ce_i) begin
      run_o <= want_run & ~estop_r & ~relock_r & ~f_bb &
               ~(want_rev & rev_inhibit_i);
      rev_o <= want_rev & ~rev_inhibit_i;
      jog_o <= term_src & jog_req;
      alt_src_o <= f_src;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      freq_sel_o <= FREQ_SOURCE;
      preset_idx_o <= 4'h0;
      ramp_sel_o <= RAMP_ACC1;
    end else if (ce_i) begin
      preset_idx_o <= pidx;
      if (jog_req) freq_sel_o <= FREQ_JOG;
      else if (pidx != 4'h0) freq_sel_o <= FREQ_PRESET;
      else freq_sel_o <= FREQ_SOURCE;
      if (jog_req) ramp_sel_o <= RAMP_JOG;
      else if (f_acc2 || estop_r) ramp_sel_o <= RAMP_ACC2;
      else ramp_sel_o <= RAMP_ACC1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      jog_freq_o <= `JOG_FREQ_MIN;
      jog_acc_o <= `JOG_TIME_MIN;
      jog_dec_o <= `JOG_TIME_MIN;
    end else if (ce_i) begin
      jog_freq_o <= clamp16(jog_freq_i, `JOG_FREQ_MIN, `JOG_FREQ_MAX);
      jog_acc_o <= 8'(clamp16({8'h00, jog_acc_i}, {8'h00, `JOG_TIME_MIN},
                              {8'h00, `JOG_TIME_MAX}));
      jog_dec_o <= 8'(clamp16({8'h00, jog_dec_i}, {8'h00, `JOG_TIME_MIN},
                              {8'h00, `JOG_TIME_MAX}));
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      estop_o <= 1'b0;
      estop_flash_o <= 1'b0;
      fault_o <= 1'b0;
      coast_o <= 1'b0;
      coast_flash_o <= 1'b0;
    end else if (ce_i) begin
      estop_o <= estop_r;
      estop_flash_o <= estop_r & flash_r;
      fault_o <= estop_r & (fault_mode_i == `FAULT_MODE_ESTOP);
      coast_o <= f_bb;
      coast_flash_o <= f_bb & flash_r;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      speed_search_o <= 1'b0;
      energy_save_o <= 1'b0;
      ramp_hold_o <= 1'b0;
      up_o <= 1'b0;
      down_o <= 1'b0;
    end else if (ce_i) begin
      speed_search_o <= f_ss & want_run & ~run_o;
      energy_save_o <= f_es;
      ramp_hold_o <= f_hold;
      up_o <= f_up & ~f_down;
      down_o <= f_down & ~f_up;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  fwd_rev_stop_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    ce_i && run_mode_i == `RUN_MODE_FWD_REV && f_fwd && f_rev && !jog_req
    |=> !run_o) else $error("fwd and rev together did not stop");
  rev_inhibit_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    rev_inhibit_i && ce_i |=> !rev_o) else $error("reverse leaked");
  jog_priority_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    ce_i && jog_req |=> freq_sel_o == FREQ_JOG && ramp_sel_o == RAMP_JOG)
    else $error("jog not prioritised");
  estop_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    ce_i && f_estop ##1 (!motor_stopped_i && ce_i) |=> estop_o)
    else $error("estop ended early");
  fault_mode_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    ce_i && fault_mode_i != `FAULT_MODE_ESTOP |=> !fault_o)
    else $error("fault without mode 9");
  base_block_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    ce_i && f_bb |=> coast_o && !run_o) else $error("no coast");
  jog_clamp_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    jog_freq_o >= `JOG_FREQ_MIN && jog_freq_o <= `JOG_FREQ_MAX)
    else $error("jog freq out of range");
  updown_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    !(up_o && down_o)) else $error("up and down together");
  level_on_scan_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $changed(tb.level) |-> tb.scan_tick)
    else $error("filtered level moved off a scan tick");
  c_run: cover property (@(posedge mclk_i) disable iff (!rst_b_i) run_o);
  c_estop: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
    estop_o ##1 !estop_o);
  c_preset: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
    freq_sel_o == FREQ_PRESET);
endmodule : drive_terminal_command_decoder

//--- src/term_cmd_defines.svh
`ifndef TERM_CMD_DEFINES_SVH
`define TERM_CMD_DEFINES_SVH

// run modes for external terminals
`define RUN_MODE_FWD_REV 2'h0
`define RUN_MODE_RUN_DIR 2'h1
`define RUN_MODE_THREE_WIRE 2'h2

// run command source codes
`define SRC_KEYPAD 2'h0
`define SRC_TERMINAL 2'h1

// terminal function codes
`define FN_FWD 5'h00
`define FN_REV 5'h01
`define FN_PRESET0 5'h02
`define FN_PRESET1 5'h03
`define FN_PRESET2 5'h04
`define FN_PRESET3 5'h05
`define FN_JOG_FWD 5'h06
`define FN_JOG_REV 5'h07
`define FN_ACC2 5'h08
`define FN_ESTOP 5'h09
`define FN_BASE_BLOCK 5'h0A
`define FN_SPEED_SEARCH 5'h0B
`define FN_ENERGY_SAVE 5'h0C
`define FN_SRC_SELECT 5'h0D
`define FN_RAMP_HOLD 5'h0E
`define FN_UP 5'h0F
`define FN_DOWN 5'h10
`define FN_LAST 5'h16

// fault output mode that reports emergency stop
`define FAULT_MODE_ESTOP 4'h9

// scan timing
`define SCAN_PERIOD_NS 2000000
`define CLK_PERIOD_NS 25
`define SCAN_CYCLES (`SCAN_PERIOD_NS / `CLK_PERIOD_NS)
`define SCAN_CNT_W 17
`define SCAN_MIN 8'h01
`define SCAN_MAX 8'hC8

// jog setting limits, 0.01 Hz and 0.1 s units
`define JOG_FREQ_MIN 16'h0064
`define JOG_FREQ_MAX 16'h09C4
`define JOG_TIME_MIN 8'h01
`define JOG_TIME_MAX 8'hFF

`endif

//--- src/term_cmd_pkg.sv
package term_cmd_pkg;
  typedef logic [4:0] func_code_t;
  typedef logic [1:0] run_mode_t;
  typedef logic [1:0] run_src_t;
  typedef logic [3:0] fault_mode_t;
  typedef enum logic [1:0] {RAMP_ACC1, RAMP_ACC2, RAMP_JOG} ramp_sel_t;
  typedef enum logic [1:0] {FREQ_SOURCE, FREQ_PRESET, FREQ_JOG} freq_sel_t;
endpackage : term_cmd_pkg

//--- src/term_bus_if.sv
`timescale 1ns/1ps
interface term_bus_if;
  logic scan_tick;
  logic [5:0] level;
  modport src (output scan_tick, output level);
  modport dst (input scan_tick, input level);
endinterface : term_bus_if

//--- src/term_scan_filter.sv
`timescale 1ns/1ps
`include "term_cmd_defines.svh"
module term_scan_filter (
  input wire logic mclk_i,          // clock
  input wire logic rst_b_i,         // async reset, low
  input wire logic ce_i,            // clock enable
  input wire logic [5:0] pin_i,     // raw terminals, async
  input wire logic [7:0] scans_i,   // required equal scans
  term_bus_if.src bus                // filtered levels
);
  logic [5:0] sync1_r;
  logic [5:0] sync2_r;
  logic [`SCAN_CNT_W-1:0] tick_cnt_r;
  logic [5:0] last_r;
  logic [7:0] same_cnt_r [6];
  logic tick;
  logic [7:0] need;

  assign tick = (tick_cnt_r == `SCAN_CNT_W'(`SCAN_CYCLES - 1));
  assign need = (scans_i < `SCAN_MIN) ? `SCAN_MIN :
                (scans_i > `SCAN_MAX) ? `SCAN_MAX : scans_i;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_r <= 6'h00;
      sync2_r <= 6'h00;
    end else if (ce_i) begin
      sync1_r <= pin_i;
      sync2_r <= sync1_r;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick_cnt_r <= '0;
    end else if (ce_i) begin
      tick_cnt_r <= tick ? '0 : tick_cnt_r + `SCAN_CNT_W'(1);
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      last_r <= 6'h00;
      bus.level <= 6'h00;
      bus.scan_tick <= 1'b0;
      for (int i = 0; i < 6; i++) same_cnt_r[i] <= 8'h00;
    end else if (ce_i) begin
      bus.scan_tick <= tick;
      if (tick) begin
        last_r <= sync2_r;
        for (int i = 0; i < 6; i++) begin
          if (sync2_r[i] != last_r[i]) begin
            same_cnt_r[i] <= 8'h01;
            if (need == 8'h01) bus.level[i] <= sync2_r[i];
          end else begin
            if (same_cnt_r[i] < need) same_cnt_r[i] <= same_cnt_r[i] + 8'h01;
            if (same_cnt_r[i] + 8'h01 >= need) bus.level[i] <= sync2_r[i];
          end
        end
      end
    end
  end
endmodule : term_scan_filter

//--- src/three_wire_latch.sv
`timescale 1ns/1ps
`include "term_cmd_defines.svh"
module three_wire_latch (
  input wire logic mclk_i,   // clock
  input wire logic rst_b_i,  // async reset, low
  input wire logic ce_i,     // clock enable
  input wire logic enable_i, // three-wire mode active
  term_bus_if.dst bus,        // filtered terminals
  output logic run_o,        // latched run
  output logic rev_o         // direction, 1 = reverse
);
  // latch on start, clear on stop open
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      run_o <= 1'b0;
      rev_o <= 1'b0;
    end else if (ce_i) begin
      rev_o <= bus.level[2];
      if (!enable_i || !bus.level[1]) begin
        run_o <= 1'b0;
      end else if (bus.level[0]) begin
        run_o <= 1'b1;
      end
    end
  end
endmodule : three_wire_latch

//--- bench/switch_bank.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// operator switch model
// ------------------------------------------------------------
module switch_bank (
  input wire logic mclk_i, // bench clock
  output logic [5:0] pins_o // terminal levels, high = closed
);
  logic [5:0] level_r = 6'h00;
  // contacts always drive a level, so no floating state to model
  // run dropped and restored by caller
  task automatic set_pins(input logic [5:0] v);
    @(posedge mclk_i);
    #2 level_r = v;
  endtask : set_pins
  assign pins_o = level_r;
endmodule : switch_bank

//--- bench/drive_terminal_command_decoder_test.sv
`timescale 1ns/1ps
module drive_terminal_command_decoder_test;
  import term_cmd_pkg::*;
  typedef struct {string n; logic [15:0] v;} note_t;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic [5:0] pins;
  func_code_t func [6];
  run_mode_t mode = 2'h2;
  run_src_t msrc = 2'h1;
  // alternate source is keypad, so selecting it must drop terminal run
  run_src_t asrc = 2'h0;
  logic ce = 1'h1;
  // zero is clamped up to a single scan
  logic [7:0] scans = 8'h00;
  logic rinh = 1'h0;
  fault_mode_t fmode = 4'h0;
  logic [15:0] jf = 16'h0064;
  logic [7:0] ja = 8'h01;
  logic [7:0] jd = 8'h01;
  logic kstop = 1'h0;
  logic krun = 1'h0;
  logic mstop = 1'h0;
  logic run, rev, jog, est, estf, coast, coastf, flt, ss, es, alt, hold;
  logic up, down;
  freq_sel_t fsel;
  ramp_sel_t rsel;
  logic [3:0] pidx;
  logic [15:0] jfo;
  logic [7:0] jao, jdo;
  logic [15:0] lfsr = 16'h0024;
  int mismatches = 0;
  int tests_run = 0;
  note_t q [$];
  note_t cur;
  event ev;
  string nm [6] = '{"coast", "ss", "es", "alt", "hold", "up"};

  always #12.5 clk = ~clk;

  switch_bank switch_bank_inst (.mclk_i(clk), .pins_o(pins));

  drive_terminal_command_decoder drive_terminal_command_decoder_inst (
    .mclk_i(clk), .rst_b_i(rst_b), .ce_i(ce), .term_pin_i(pins),
    .func_i(func), .run_mode_i(mode), .main_src_i(msrc),
    .alt_src_i(asrc), .rev_inhibit_i(rinh), .scan_count_i(scans),
    .fault_mode_i(fmode), .jog_freq_i(jf), .jog_acc_i(ja),
    .jog_dec_i(jd), .key_stop_i(kstop), .key_run_i(krun),
    .motor_stopped_i(mstop), .run_o(run), .rev_o(rev), .jog_o(jog),
    .freq_sel_o(fsel), .preset_idx_o(pidx), .ramp_sel_o(rsel),
    .jog_freq_o(jfo), .jog_acc_o(jao), .jog_dec_o(jdo),
    .estop_o(est), .estop_flash_o(estf), .coast_o(coast),
    .coast_flash_o(coastf), .fault_o(flt), .speed_search_o(ss),
    .energy_save_o(es), .alt_src_o(alt), .ramp_hold_o(hold),
    .up_o(up), .down_o(down));

  function automatic logic [15:0] obs(input string n);
    case (n)
      "run": obs = {15'h0000, run};
      "rev": obs = {15'h0000, rev};
      "jog": obs = {15'h0000, jog};
      "fsel": obs = {14'h0000, fsel};
      "rsel": obs = {14'h0000, rsel};
      "pidx": obs = {12'h000, pidx};
      "jfreq": obs = jfo;
      "jacc": obs = {8'h00, jao};
      "jdec": obs = {8'h00, jdo};
      "estop": obs = {15'h0000, est};
      "estf": obs = {15'h0000, estf};
      "coastf": obs = {15'h0000, coastf};
      "fault": obs = {15'h0000, flt};
      "coast": obs = {15'h0000, coast};
      "ss": obs = {15'h0000, ss};
      "es": obs = {15'h0000, es};
      "alt": obs = {15'h0000, alt};
      "hold": obs = {15'h0000, hold};
      "up": obs = {15'h0000, up};
      default: obs = {15'h0000, down};
    endcase
  endfunction : obs

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  // outputs are registered levels, three edges covers any config change
  task automatic step();
    repeat (3) @(posedge clk);
    #2;
  endtask : step

  task automatic chk(input string n, input logic [15:0] v);
    q.push_back('{n, v});
    ->ev;
    #1;
  endtask : chk

  // bounded wait across one 2 ms scan tick
  task automatic wait_for(input string n, input logic [15:0] v);
    int i;
    for (i = 0; i < 90000 && obs(n) !== v; i++) begin
      @(posedge clk);
    end
    #2;
    chk(n, v);
    if (i >= 90000) end_of_test();
  endtask : wait_for

  always @(ev) begin
    cur = q.pop_front();
    tests_run++;
    if (obs(cur.n) !== cur.v) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", cur.n, cur.v,
               obs(cur.n));
    end
  end

  initial begin
    foreach (func[i]) func[i] = 5'h19;
    repeat (5) @(posedge clk);
    #2 rst_b = 1'h1;
    // one scan tick costs 80000 cycles, so the levels are set only once
    for (int i = 0; i < 3; i++) func[i] = 5'h09;
    switch_bank_inst.set_pins(6'h3F);
    step();
    chk("run", 16'h0000);
    wait_for("run", 16'h0001);
    chk("rev", 16'h0001);
    chk("estop", 16'h0000);
    mode = 2'h0;
    step();
    chk("estop", 16'h0001);
    foreach (func[i]) func[i] = 5'h19;
    mstop = 1'h1;
    step();
    mstop = 1'h0;
    func[0] = 5'h00;
    step();
    chk("run", 16'h0001);
    $display("three wire test done");
    func[1] = 5'h01;
    step();
    chk("run", 16'h0000);
    mode = 2'h1;
    step();
    chk("rev", 16'h0001);
    mode = 2'h0;
    func[0] = 5'h19;
    step();
    chk("rev", 16'h0001);
    rinh = 1'h1;
    step();
    chk("run", 16'h0000);
    rinh = 1'h0;
    msrc = 2'h0;
    step();
    chk("run", 16'h0000);
    msrc = 2'h1;
    func[1] = 5'h19;
    $display("direction test done");
    for (int k = 0; k < 16; k++) begin
      for (int i = 0; i < 4; i++) func[i] = k[i] ? 5'(i + 2) : 5'h19;
      step();
      chk("pidx", 16'(k));
      chk("fsel", k != 0 ? 16'(FREQ_PRESET) : 16'(FREQ_SOURCE));
    end
    func[5] = 5'h06;
    step();
    chk("fsel", 16'(FREQ_JOG));
    chk("rsel", 16'(RAMP_JOG));
    chk("jog", 16'h0001);
    func[5] = 5'h08;
    step();
    chk("rsel", 16'(RAMP_ACC2));
    // forward held so speed search sees a start after base block
    func[4] = 5'h00;
    for (int c = 0; c < 6; c++) begin
      func[5] = 5'(c + 10);
      if (c == 1) begin
        @(posedge clk);
        #2;
        chk("ss", 16'h0001);
      end
      step();
      chk(nm[c], {15'h0000, c != 1});
      if (c == 0) chk("coastf", 16'h0001);
      if (c == 3) chk("run", 16'h0000);
    end
    func[4] = 5'h0F;
    func[5] = 5'h10;
    step();
    chk("up", 16'h0000);
    chk("down", 16'h0000);
    $display("function code test done");
    foreach (func[i]) func[i] = 5'h19;
    func[0] = 5'h00;
    func[5] = 5'h09;
    step();
    chk("estop", 16'h0001);
    chk("fault", 16'h0000);
    chk("estf", 16'h0001);
    // clock enable low must freeze the fault output
    ce = 1'h0;
    fmode = 4'h9;
    step();
    chk("fault", 16'h0000);
    ce = 1'h1;
    step();
    chk("fault", 16'h0001);
    func[5] = 5'h19;
    step();
    chk("estop", 16'h0001);
    mstop = 1'h1;
    step();
    chk("run", 16'h0000);
    func[0] = 5'h19;
    step();
    func[0] = 5'h00;
    step();
    chk("run", 16'h0001);
    mstop = 1'h0;
    kstop = 1'h1;
    step();
    chk("estop", 16'h0001);
    kstop = 1'h0;
    mstop = 1'h1;
    step();
    mstop = 1'h0;
    krun = 1'h1;
    step();
    chk("run", 16'h0001);
    krun = 1'h0;
    $display("emergency stop test done");
    for (int n = 0; n < 10; n++) begin
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      jf = n == 0 ? 16'h0000 : (n == 1 ? 16'hFFFF : lfsr);
      ja = lfsr[7:0];
      jd = lfsr[15:8];
      step();
      chk("jfreq", jf < 16'h0064 ? 16'h0064 :
          (jf > 16'h09C4 ? 16'h09C4 : jf));
      chk("jacc", ja == 8'h00 ? 16'h0001 : {8'h00, ja});
      chk("jdec", jd == 8'h00 ? 16'h0001 : {8'h00, jd});
    end
    $display("jog limit test done");
    end_of_test();
  end
endmodule : drive_terminal_command_decoder_test
